/* rtl/ppcd_pkg.sv */
// Constants and types of the PSI5 programming command decoder
package ppcd_pkg;
  // Timing
  localparam int CLK_NS      = 50;
  localparam int CLK_MHZ     = 20;
  localparam int BIT_NS      = 400;
  localparam int BIT_CYC     = BIT_NS / CLK_NS;
  localparam int ZERO_AT     = BIT_CYC + BIT_CYC / 2;
  localparam int BLANK_NS    = 150;
  localparam int BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  // Command framing
  localparam int START_ZEROS = 5;
  localparam int START_ONES  = 31;
  localparam int MISS_LIMIT  = 4;
  localparam int FC_LSB      = 3;
  localparam int RA_LSB      = 6;
  localparam int D_LSB       = 12;
  localparam int SHORT_BITS  = 6;
  localparam int LONG_BITS   = 16;
  localparam int CRC_BITS    = 3;
  localparam logic [2:0] START_SEQ   = 3'h2;
  localparam logic [2:0] SENSOR_ADDR = 3'h1;
  localparam logic [2:0] CRC_SEED    = 3'h7;
  localparam logic [2:0] CRC_POLY    = 3'h3;
  localparam logic [2:0] FC_BURN     = 3'h4;
  localparam logic [2:0] FC_ENTER    = 3'h7;
  localparam logic [2:0] FC_READ     = 3'h2;
  localparam logic [2:0] FC_WRITE    = 3'h3;
  // Response words and error numbers
  localparam logic [9:0] RESP_OK     = 10'h1e1;
  localparam logic [9:0] RESP_ERR    = 10'h1e2;
  localparam logic [9:0] ACK_BURN    = 10'h2aa;
  localparam logic [9:0] ACK_ENTER   = 10'h0ca;
  localparam logic [3:0] ERR_FRAMING = 4'h1;
  localparam logic [3:0] ERR_CRC     = 4'h2;
  localparam logic [3:0] ERR_RANGE   = 4'h5;
  localparam logic [3:0] ERR_LOCKED  = 4'h6;
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LOCK   = 8'h08;
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_BLANK_BIT = 1;
  localparam int ST_PROG        = 0;
  localparam int ST_BUSY        = 1;
  localparam int ST_DONE        = 2;
  localparam int ST_FAIL        = 3;
  localparam int ST_ERR_LSB     = 4;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_HUNT  = 3'h0,
    PH_RECV  = 3'h1,
    PH_RESP  = 3'h3,
    PH_DELAY = 3'h2,
    PH_BURN  = 3'h6
  } ppcd_phase_t;

  typedef struct packed {
    logic dataLen10;
    logic evenParity;
    logic baud125;
    logic firstSlot;
    logic pulldownOff;
  } ppcd_resp_fmt_t;

  localparam ppcd_resp_fmt_t RESP_FMT = 5'h1f;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } ppcd_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ppcd_axil_rsp_t;
endpackage

/* rtl/ppcd_decoder.sv */
// PSI5 programming-mode command decoder with shadow registers and OTP burn sequencing
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module ppcd_decoder #(
  parameter int ARRAY_BYTES   = 32,
  parameter int PROG_DELAY_US = 100,
  parameter int OTP_WRITE_US  = 2000
) (
  input  wire logic                     mclk,       // System clock, 20 MHz
  input  wire logic                     reset,      // Synchronous reset, active high
  input  wire logic                     syncIn,     // Sync pulse detector level
  input  wire logic                     vppIn,      // Programming supply present
  input  wire ppcd_pkg::ppcd_axil_req_t axiReq,     // AXI4-Lite requests
  output ppcd_pkg::ppcd_axil_rsp_t      axiRsp,     // AXI4-Lite answers
  output logic                          respValid,  // One-cycle response word strobe
  output logic [9:0]                    respWord,   // Response word for the slot
  output ppcd_pkg::ppcd_resp_fmt_t      respFmt,    // Fixed response encoding
  output logic                          otpBurnEn   // OTP array write in progress
);

  localparam int PROG_DELAY_CYC = PROG_DELAY_US * ppcd_pkg::CLK_MHZ;
  localparam int OTP_WRITE_CYC  = OTP_WRITE_US * ppcd_pkg::CLK_MHZ;

  typedef struct packed {
    logic                          sync1;
    logic                          sync2;
    logic                          syncPrev;
    logic                          vpp1;
    logic                          vpp2;
    logic [3:0]                    blank;
    logic [4:0]                    bitTmr;
    ppcd_pkg::ppcd_phase_t         phase;
    logic                          primed;
    logic [1:0]                    hist;
    logic [2:0]                    zeroRun;
    logic [4:0]                    oneRun;
    logic [1:0]                    stuffCnt;
    logic [4:0]                    dcnt;
    logic [15:0]                   pay;
    logic [2:0]                    crc;
    logic [2:0]                    rxCrc;
    logic [2:0]                    miss;
    logic [2:0][9:0]               rw;
    logic [1:0]                    rcnt;
    logic [1:0]                    rlen;
    logic                          burnPend;
    logic                          respValid;
    logic [9:0]                    respWord;
    logic                          progMode;
    logic                          loadDone;
    logic                          burnFail;
    logic                          burnVpp;
    logic [3:0]                    lastErr;
    logic                          ctrlEn;
    logic                          blankSel;
    logic [31:0]                   lock;
    logic [31:0]                   cnt;
    logic [ARRAY_BYTES-1:0][7:0]   shadow;
    logic [ARRAY_BYTES-1:0][7:0]   otp;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
  } ppcd_state_t;

  ppcd_state_t r_r;
  ppcd_state_t r_nxt;

  logic        syncEdge;
  logic        bitZero;
  logic        bitValid;
  logic        bitVal;
  logic        isShort;
  logic [4:0]  payLen;
  logic [2:0]  sensorAddr;
  logic [2:0]  funcCode;
  logic [5:0]  nibbleAddr;
  logic [3:0]  dataNibble;
  logic [4:0]  byteIdx;
  logic        inRange;
  logic [7:0]  curByte;
  logic [7:0]  nextByte;
  logic [7:0]  newByte;
  logic [2:0]  crcFinal;
  logic        crcOk;
  logic        longErr;
  logic [3:0]  longErrNum;
  logic        wrGo;
  logic        rdGo;
  logic [31:0] statusWord;
  logic [31:0] readWord;

  function automatic logic [2:0] crcStep(input logic [2:0] c, input logic b);
    crcStep = {c[1:0], b} ^ (c[2] ? ppcd_pkg::CRC_POLY : 3'h0);
  endfunction

  function automatic logic [1:0] regSel(input logic [ppcd_pkg::ADDR_W-1:0] a);
    logic [ppcd_pkg::ADDR_W-1:0] w;
    w = {a[ppcd_pkg::ADDR_W-1:2], 2'h0};
    if (w == ppcd_pkg::REG_CTRL) begin
      regSel = 2'h0;
    end else if (w == ppcd_pkg::REG_STATUS) begin
      regSel = 2'h1;
    end else if (w == ppcd_pkg::REG_LOCK) begin
      regSel = 2'h2;
    end else begin
      regSel = 2'h3;
    end
  endfunction

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[8*i +: 8] = d[8*i +: 8];
      end
    end
    return v;
  endfunction

  // Field decode of the frame being received
  always_comb begin
    sensorAddr = r_r.pay[ppcd_pkg::FC_LSB-1:0];
    funcCode   = r_r.pay[ppcd_pkg::RA_LSB-1:ppcd_pkg::FC_LSB];
    nibbleAddr = r_r.pay[ppcd_pkg::D_LSB-1:ppcd_pkg::RA_LSB];
    dataNibble = r_r.pay[ppcd_pkg::LONG_BITS-1:ppcd_pkg::D_LSB];
    isShort    = funcCode[2];
    payLen     = isShort ? 5'(ppcd_pkg::SHORT_BITS) : 5'(ppcd_pkg::LONG_BITS);
    byteIdx    = nibbleAddr[5:1];
    inRange    = {1'b0, byteIdx} < 6'(ARRAY_BYTES);
    curByte    = inRange ? r_r.shadow[byteIdx] : 8'h00;
    if (!inRange || byteIdx == 5'(ARRAY_BYTES - 1)) begin
      nextByte = 8'h00;
    end else begin
      nextByte = r_r.shadow[byteIdx + 5'h1];
    end
    if (nibbleAddr[0]) begin
      newByte = {dataNibble, curByte[3:0]};
    end else begin
      newByte = {curByte[7:4], dataNibble};
    end
    crcFinal = crcStep(crcStep(crcStep(r_r.crc, 1'b0), 1'b0), 1'b0);
    crcOk    = crcFinal == {r_r.rxCrc[1:0], bitVal};
    longErr    = 1'b1;
    longErrNum = ppcd_pkg::ERR_CRC;
    if (crcOk) begin
      if (!inRange) begin
        longErrNum = ppcd_pkg::ERR_RANGE;
      end else if (funcCode == ppcd_pkg::FC_WRITE && r_r.lock[byteIdx]) begin
        longErrNum = ppcd_pkg::ERR_LOCKED;
      end else begin
        longErr = 1'b0;
      end
    end
  end

  // Bus handshake and register read mux
  always_comb begin
    wrGo = axiReq.awvalid & axiReq.wvalid & ~r_r.bvalid;
    rdGo = axiReq.arvalid & ~r_r.rvalid;
    statusWord = 32'h0;
    statusWord[ppcd_pkg::ST_PROG] = r_r.progMode;
    statusWord[ppcd_pkg::ST_BUSY] = r_r.phase == ppcd_pkg::PH_DELAY ||
                                    r_r.phase == ppcd_pkg::PH_BURN;
    statusWord[ppcd_pkg::ST_DONE] = r_r.loadDone;
    statusWord[ppcd_pkg::ST_FAIL] = r_r.burnFail;
    statusWord[ppcd_pkg::ST_ERR_LSB +: 4] = r_r.lastErr;
    readWord = 32'h0;
    unique case (regSel(axiReq.araddr))
      2'h0: begin
        readWord[ppcd_pkg::CTRL_EN_BIT]    = r_r.ctrlEn;
        readWord[ppcd_pkg::CTRL_BLANK_BIT] = r_r.blankSel;
      end
      2'h1: readWord = statusWord;
      2'h2: readWord = r_r.lock;
      2'h3: readWord = 32'h0;
    endcase
  end

  // Next-state logic
  always_comb begin
    r_nxt           = r_r;
    r_nxt.sync1     = syncIn;
    r_nxt.sync2     = r_r.sync1;
    r_nxt.syncPrev  = r_r.sync2;
    r_nxt.vpp1      = vppIn;
    r_nxt.vpp2      = r_r.vpp1;
    r_nxt.respValid = 1'b0;

    // Sync pulse edge, blanked for a fixed time and ignored during the programming delay and while burning
    syncEdge = r_r.sync2 & ~r_r.syncPrev & (r_r.blank == 4'h0) &
               (r_r.phase != ppcd_pkg::PH_DELAY) & (r_r.phase != ppcd_pkg::PH_BURN);
    if (r_r.blank != 4'h0) begin
      r_nxt.blank = r_r.blank - 4'h1;
    end
    if (syncEdge) begin
      r_nxt.blank = 4'(ppcd_pkg::BLANK_CYC);
    end

    // A pulse is a one; no pulse by 1.5 slots is a zero
    bitZero  = ~syncEdge & (r_r.bitTmr == 5'(ppcd_pkg::ZERO_AT));
    bitValid = syncEdge | bitZero;
    bitVal   = syncEdge;
    if (syncEdge) begin
      r_nxt.bitTmr = 5'h0;
    end else if (bitZero) begin
      r_nxt.bitTmr = 5'(ppcd_pkg::BIT_CYC / 2);
    end else begin
      r_nxt.bitTmr = r_r.bitTmr + 5'h1;
    end

    unique case (r_r.phase)
      ppcd_pkg::PH_HUNT: begin
        if (bitValid) begin
          r_nxt.hist = {r_r.hist[0], bitVal};
          if (bitVal) begin
            r_nxt.zeroRun = 3'h0;
            r_nxt.oneRun  = (r_r.oneRun == 5'h1f) ? r_r.oneRun : r_r.oneRun + 5'h1;
          end else begin
            r_nxt.oneRun  = 5'h0;
            r_nxt.zeroRun = (r_r.zeroRun == 3'h7) ? r_r.zeroRun : r_r.zeroRun + 3'h1;
          end
          if (r_r.zeroRun >= 3'(ppcd_pkg::START_ZEROS) ||
              r_r.oneRun >= 5'(ppcd_pkg::START_ONES)) begin
            r_nxt.primed = 1'b1;
          end
          if (r_r.ctrlEn && r_r.primed && {r_r.hist, bitVal} == ppcd_pkg::START_SEQ) begin
            r_nxt.phase    = ppcd_pkg::PH_RECV;
            r_nxt.primed   = 1'b0;
            r_nxt.stuffCnt = 2'h0;
            r_nxt.dcnt     = 5'h0;
            r_nxt.pay      = 16'h0;
            r_nxt.miss     = 3'h0;
            r_nxt.crc      = ppcd_pkg::CRC_SEED;
          end
        end
      end

      ppcd_pkg::PH_RECV: begin
        if (bitValid) begin
          r_nxt.stuffCnt = r_r.stuffCnt + 2'h1;
          r_nxt.miss     = bitVal ? 3'h0 : r_r.miss + 3'h1;
          r_nxt.rcnt     = 2'h0;
          r_nxt.burnPend = 1'b0;
          if (!bitVal && r_r.miss == 3'(ppcd_pkg::MISS_LIMIT - 1)) begin
            // Abort; the next pulse gets a short framing error answer
            r_nxt.phase   = ppcd_pkg::PH_RESP;
            r_nxt.rw[0]   = ppcd_pkg::RESP_ERR;
            r_nxt.rw[1]   = {6'h0, ppcd_pkg::ERR_FRAMING};
            r_nxt.rlen    = 2'h2;
            r_nxt.lastErr = ppcd_pkg::ERR_FRAMING;
          end else if (r_r.stuffCnt == 2'h0) begin
            r_nxt.dcnt = r_r.dcnt;
          end else if (r_r.dcnt < payLen) begin
            r_nxt.pay[r_r.dcnt[3:0]] = bitVal;
            r_nxt.crc  = crcStep(r_r.crc, bitVal);
            r_nxt.dcnt = r_r.dcnt + 5'h1;
          end else if (r_r.dcnt != payLen + 5'(ppcd_pkg::CRC_BITS - 1)) begin
            r_nxt.rxCrc = {r_r.rxCrc[1:0], bitVal};
            r_nxt.dcnt  = r_r.dcnt + 5'h1;
          end else begin
            r_nxt.phase = ppcd_pkg::PH_HUNT;
            if (sensorAddr == ppcd_pkg::SENSOR_ADDR) begin
              if (isShort) begin
                if (funcCode == ppcd_pkg::FC_BURN) begin
                  r_nxt.phase = ppcd_pkg::PH_RESP;
                  r_nxt.rlen  = 2'h2;
                  if (crcOk) begin
                    r_nxt.rw[0]    = ppcd_pkg::RESP_OK;
                    r_nxt.rw[1]    = ppcd_pkg::ACK_BURN;
                    r_nxt.burnPend = 1'b1;
                  end else begin
                    r_nxt.rw[0]   = ppcd_pkg::RESP_ERR;
                    r_nxt.rw[1]   = {6'h0, ppcd_pkg::ERR_CRC};
                    r_nxt.lastErr = ppcd_pkg::ERR_CRC;
                  end
                end else if (funcCode == ppcd_pkg::FC_ENTER && crcOk) begin
                  r_nxt.phase    = ppcd_pkg::PH_RESP;
                  r_nxt.progMode = 1'b1;
                  r_nxt.rw[0]    = ppcd_pkg::RESP_OK;
                  r_nxt.rw[1]    = ppcd_pkg::ACK_ENTER;
                  r_nxt.rlen     = 2'h2;
                end
              end else if (funcCode == ppcd_pkg::FC_READ ||
                           funcCode == ppcd_pkg::FC_WRITE) begin
                r_nxt.phase = ppcd_pkg::PH_RESP;
                r_nxt.rlen  = 2'h3;
                if (longErr) begin
                  r_nxt.rw[0]   = ppcd_pkg::RESP_ERR;
                  r_nxt.rw[1]   = {6'h0, longErrNum};
                  r_nxt.rw[2]   = 10'h000;
                  r_nxt.lastErr = longErrNum;
                end else if (funcCode == ppcd_pkg::FC_READ) begin
                  r_nxt.rw[0] = ppcd_pkg::RESP_OK;
                  r_nxt.rw[1] = {2'h0, curByte};
                  r_nxt.rw[2] = {2'h0, nextByte};
                end else begin
                  r_nxt.shadow[byteIdx] = newByte;
                  r_nxt.rw[0] = ppcd_pkg::RESP_OK;
                  r_nxt.rw[1] = {2'h0, newByte};
                  r_nxt.rw[2] = {4'h0, nibbleAddr};
                end
              end
            end
          end
        end
      end

      ppcd_pkg::PH_RESP: begin
        if (syncEdge) begin
          r_nxt.respValid = 1'b1;
          r_nxt.respWord  = r_r.rw[r_r.rcnt];
          r_nxt.rcnt      = r_r.rcnt + 2'h1;
          if (r_r.rcnt == r_r.rlen - 2'h1) begin
            r_nxt.phase   = r_r.burnPend ? ppcd_pkg::PH_DELAY : ppcd_pkg::PH_HUNT;
            r_nxt.primed  = 1'b0;
            r_nxt.hist    = 2'h0;
            r_nxt.zeroRun = 3'h0;
            r_nxt.oneRun  = 5'h0;
            r_nxt.cnt     = 32'h0;
            if (r_r.burnPend) begin
              r_nxt.loadDone = 1'b0;
              r_nxt.burnFail = 1'b0;
            end
          end
        end
      end

      ppcd_pkg::PH_DELAY: begin
        r_nxt.cnt = r_r.cnt + 32'h1;
        if (r_r.cnt == 32'(PROG_DELAY_CYC - 1)) begin
          r_nxt.cnt     = 32'h0;
          r_nxt.burnVpp = r_r.vpp2;
          r_nxt.phase   = ppcd_pkg::PH_BURN;
        end
      end

      ppcd_pkg::PH_BURN: begin
        r_nxt.cnt = r_r.cnt + 32'h1;
        if (r_r.cnt == 32'(OTP_WRITE_CYC - 1)) begin
          r_nxt.phase = ppcd_pkg::PH_HUNT;
          if (r_r.burnVpp) begin
            // Fuses only gain ones; shadows reload from the burnt array
            r_nxt.otp      = r_r.otp | r_r.shadow;
            r_nxt.shadow   = r_r.otp | r_r.shadow;
            r_nxt.loadDone = 1'b1;
          end else begin
            r_nxt.burnFail = 1'b1;
          end
        end
      end

      default: begin
        r_nxt.phase = ppcd_pkg::PH_HUNT;
      end
    endcase

    // Register writes
    if (r_r.bvalid && axiReq.bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (wrGo) begin
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = ppcd_pkg::AXI_OKAY;
      unique case (regSel(axiReq.awaddr))
        2'h0: begin
          if (axiReq.wstrb[0]) begin
            r_nxt.ctrlEn   = axiReq.wdata[ppcd_pkg::CTRL_EN_BIT];
            r_nxt.blankSel = axiReq.wdata[ppcd_pkg::CTRL_BLANK_BIT];
          end
        end
        2'h1: r_nxt.bresp = ppcd_pkg::AXI_OKAY;
        2'h2: r_nxt.lock  = applyStrb(r_r.lock, axiReq.wdata, axiReq.wstrb);
        2'h3: r_nxt.bresp = ppcd_pkg::AXI_SLVERR;
      endcase
    end

    // Register reads
    if (r_r.rvalid && axiReq.rready) begin
      r_nxt.rvalid = 1'b0;
    end
    if (rdGo) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata  = readWord;
      r_nxt.rresp  = (regSel(axiReq.araddr) == 2'h3) ? ppcd_pkg::AXI_SLVERR
                                                     : ppcd_pkg::AXI_OKAY;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r_r        <= '0;
      r_r.ctrlEn <= 1'b1;
      r_r.crc    <= ppcd_pkg::CRC_SEED;
    end else begin
      r_r <= r_nxt;
    end
  end

  always_comb begin
    axiRsp         = '0;
    axiRsp.awready = wrGo;
    axiRsp.wready  = wrGo;
    axiRsp.bvalid  = r_r.bvalid;
    axiRsp.bresp   = r_r.bresp;
    axiRsp.arready = rdGo;
    axiRsp.rvalid  = r_r.rvalid;
    axiRsp.rdata   = r_r.rdata;
    axiRsp.rresp   = r_r.rresp;
  end

  assign respValid = r_r.respValid;
  assign respWord  = r_r.respWord;
  assign respFmt   = ppcd_pkg::RESP_FMT;
  assign otpBurnEn = r_r.phase == ppcd_pkg::PH_BURN;

endmodule

/* test/ppcd_decoder_props.sv */
// Assertion checker bound to the PSI5 programming command decoder
`timescale 1ns/1ps
module ppcd_decoder_props #(
  parameter int ARRAY_BYTES   = 32,
  parameter int PROG_DELAY_US = 100,
  parameter int OTP_WRITE_US  = 2000
) (
  input wire logic                     mclk,      // Clock
  input wire logic                     reset,     // Reset
  input wire logic                     syncIn,    // Sync
  input wire logic                     vppIn,     // Supply
  input wire ppcd_pkg::ppcd_axil_req_t axiReq,    // Bus in
  input wire ppcd_pkg::ppcd_axil_rsp_t axiRsp,    // Bus out
  input wire logic                     respValid, // Strobe
  input wire logic [9:0]               respWord,  // Word
  input wire ppcd_pkg::ppcd_resp_fmt_t respFmt,   // Format
  input wire logic                     otpBurnEn  // Burn
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_err;
    respValid && respWord == 10'h1e2;
  endsequence
  sequence s_error_number;
    respValid && respWord[9:4] == 6'h0 && respWord[3:0] inside {4'h1, 4'h2, 4'h5, 4'h6};
  endsequence
  property p_err; s_err |-> ##[1:40] s_error_number; endproperty
  a_err: assert property (p_err) else $error("bad error word");
  property p_fmt; respFmt == 5'h1f; endproperty
  a_fmt: assert property (p_fmt) else $error("format changed");
  property p_quiet; otpBurnEn |-> !respValid; endproperty
  a_quiet: assert property (p_quiet) else $error("answer in burn");
  property p_gap; respValid |=> !respValid [*7]; endproperty
  a_gap: assert property (p_gap) else $error("two answers in a slot");
  property p_hold; !respValid |-> $stable(respWord); endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_wtake; axiReq.awvalid && axiReq.wvalid && !axiRsp.bvalid |=> axiRsp.bvalid; endproperty
  a_wtake: assert property (p_wtake) else $error("no write answer");
  property p_rtake; axiReq.arvalid && !axiRsp.rvalid |=> axiRsp.rvalid; endproperty
  a_rtake: assert property (p_rtake) else $error("no read answer");
  property p_rdata; axiRsp.rvalid && axiRsp.rresp != 2'h0 |-> axiRsp.rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("error read not zero");
endmodule
bind ppcd_decoder ppcd_decoder_props #(
  .ARRAY_BYTES(ARRAY_BYTES), .PROG_DELAY_US(PROG_DELAY_US), .OTP_WRITE_US(OTP_WRITE_US)
) u_props (
  .mclk(mclk), .reset(reset), .syncIn(syncIn), .vppIn(vppIn), .axiReq(axiReq),
  .axiRsp(axiRsp), .respValid(respValid), .respWord(respWord), .respFmt(respFmt),
  .otpBurnEn(otpBurnEn)
);

/* test/ppcd_psi5_master.sv */
// Command master model that sends frames as sync pulses
`timescale 1ns/1ps
module ppcd_psi5_master (
  input  wire logic mclk,   // Clock
  output logic      syncIn  // Sync pulse
);
  initial syncIn = 1'b0;
  task automatic slot(input logic b);
    syncIn <= b;
    @(posedge mclk);
    syncIn <= 1'b0;
    repeat (7) @(posedge mclk);
  endtask
  task automatic frame(input logic [2:0] sa, input logic [2:0] fc, input logic [5:0] ra,
                       input logic [3:0] d, input logic bad);
    logic [18:0] m;
    logic [2:0]  c;
    int          n;
    m = {3'h0, d, ra, fc, sa};
    n = fc[2] ? 6 : 16;
    c = 3'h7;
    for (int i = 0; i < n + 3; i++) c = {c[1:0], i < n && m[i]} ^ (c[2] ? 3'h3 : 3'h0);
    m[n +: 3] = {c[0], c[1], c[2] ^ bad};
    repeat (7) slot(1'b0);
    slot(1'b1);
    slot(1'b0);
    for (int i = 0; i < n + 3; i++) begin
      if (i % 3 == 0) slot(1'b1);
      slot(m[i]);
    end
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the PSI5 programming command decoder
`timescale 1ns/1ps
module tb_top;
  logic                     mclk, reset, vppIn, syncIn, respValid, otpBurnEn;
  logic [9:0]               respWord;
  ppcd_pkg::ppcd_resp_fmt_t respFmt;
  ppcd_pkg::ppcd_axil_req_t req;
  ppcd_pkg::ppcd_axil_rsp_t rsp;
  logic [9:0]               got[$];
  logic [33:0]              cap;
  int                       errorCnt = 0;
  int                       samplesChecked = 0;
  ppcd_psi5_master master (.mclk(mclk), .syncIn(syncIn));
  ppcd_decoder #(.ARRAY_BYTES(16), .PROG_DELAY_US(1), .OTP_WRITE_US(1)) dut (
    .mclk(mclk), .reset(reset), .syncIn(syncIn), .vppIn(vppIn), .axiReq(req), .axiRsp(rsp),
    .respValid(respValid), .respWord(respWord), .respFmt(respFmt), .otpBurnEn(otpBurnEn));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk) if (respValid === 1'b1) got.push_back(respWord);
  task automatic completeRun;
    $display("errors %0d checks %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    samplesChecked++;
    if (s !== e) begin
      errorCnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic hs(input int k);
    logic [5:0] v;
    int         t;
    for (t = 0; t < 99; t++) begin
      @(negedge mclk);
      v = {!otpBurnEn, otpBurnEn, rsp.rvalid, rsp.arready, rsp.bvalid, rsp.awready};
      cap = {k == 1 ? rsp.bresp : rsp.rresp, rsp.rdata};
      if (v[k] === 1'b1) break;
    end
    if (t == 99) begin
      errorCnt++;
      completeRun();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    hs(0);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    hs(1);
    chk(34'(cap[33:32]), 34'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] d);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    hs(2);
    req.arvalid <= 1'b0;
    hs(3);
    chk(cap, {e, d});
  endtask
  task automatic ans(input int n, input logic [29:0] x);
    repeat (n == 0 ? 3 : n) master.slot(1'b1);
    chk(34'(got.size()), 34'(n));
    for (int i = 0; i < n; i++) chk(34'(got[i]), 34'(x[29 - 10 * i -: 10]));
    got.delete();
    $display("frame test done at %0t", $time);
  endtask
  task automatic run(input logic [2:0] fc, input logic [5:0] ra, input logic [3:0] d,
                     input logic bad, input int n, input logic [29:0] x);
    master.frame(3'h1, fc, ra, d, bad);
    ans(n, x);
  endtask
  initial begin
    reset = 1'b1;
    vppIn = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hf;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd(8'h00, 2'h0, 32'h1);
    rd(8'h0c, 2'h2, 32'h0);
    wr(8'h0c, 32'h1, 2'h2);
    wr(8'h00, 32'h3, 2'h0);
    rd(8'h00, 2'h0, 32'h3);
    wr(8'h04, 32'hf, 2'h0);
    chk(34'(respFmt), 34'(5'h1f));
    $display("register test done at %0t", $time);
    run(3'h7, 6'h0, 4'h0, 1'b0, 2, {10'h1e1, 10'h0ca, 10'h0});
    rd(8'h04, 2'h0, 32'h1);
    run(3'h7, 6'h0, 4'h0, 1'b1, 0, 30'h0);
    for (int f = 0; f < 7; f++) begin
      if (f inside {0, 1, 5, 6}) run(3'(f), 6'h0, 4'h0, 1'b0, 0, 30'h0);
    end
    master.frame(3'h2, 3'h2, 6'h4, 4'h0, 1'b0);
    ans(0, 30'h0);
    run(3'h3, 6'h05, 4'ha, 1'b0, 3, {10'h1e1, 10'h0a0, 10'h005});
    run(3'h3, 6'h04, 4'h5, 1'b0, 3, {10'h1e1, 10'h0a5, 10'h004});
    run(3'h3, 6'h06, 4'h7, 1'b0, 3, {10'h1e1, 10'h007, 10'h006});
    run(3'h2, 6'h04, 4'h0, 1'b0, 3, {10'h1e1, 10'h0a5, 10'h007});
    run(3'h2, 6'h05, 4'h0, 1'b1, 3, {10'h1e2, 10'h002, 10'h000});
    run(3'h3, 6'h1e, 4'h3, 1'b0, 3, {10'h1e1, 10'h003, 10'h01e});
    run(3'h2, 6'h1f, 4'h0, 1'b0, 3, {10'h1e1, 10'h003, 10'h000});
    run(3'h2, 6'h22, 4'h0, 1'b0, 3, {10'h1e2, 10'h005, 10'h000});
    wr(8'h08, 32'h2, 2'h0);
    run(3'h3, 6'h02, 4'h1, 1'b0, 3, {10'h1e2, 10'h006, 10'h000});
    run(3'h4, 6'h0, 4'h0, 1'b1, 2, {10'h1e2, 10'h002, 10'h0});
    repeat (7) master.slot(1'b0);
    for (int i = 0; i < 10; i++) master.slot(i == 0 || i == 2 || i == 3);
    ans(2, {10'h1e2, 10'h001, 10'h0});
    vppIn <= 1'b1;
    run(3'h4, 6'h0, 4'h0, 1'b0, 2, {10'h1e1, 10'h2aa, 10'h0});
    hs(4);
    hs(5);
    rd(8'h04, 2'h0, 32'h15);
    run(3'h2, 6'h04, 4'h0, 1'b0, 3, {10'h1e1, 10'h0a5, 10'h007});
    vppIn <= 1'b0;
    run(3'h4, 6'h0, 4'h0, 1'b0, 2, {10'h1e1, 10'h2aa, 10'h0});
    hs(4);
    hs(5);
    rd(8'h04, 2'h0, 32'h19);
    completeRun();
  end
endmodule
